/* File: xpd_params.svh */
// Register offsets, field positions and reset values of the peripheral enable decoder.
`ifndef XPD_PARAMS_SVH
`define XPD_PARAMS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define XPD_ADDR_W          8
`define XPD_OFS_PERIPH_EN   8'h00
`define XPD_OFS_SYS_CFG     8'h04
`define XPD_OFS_STATUS      8'h08
`define XPD_OFS_EFFECTIVE   8'h0c

// ----------------------------------------------------------------
// Peripheral enable fields
// ----------------------------------------------------------------
`define XPD_EN_W            12
`define XPD_BIT_FIRST_CAN   0
`define XPD_BIT_SECOND_CAN  1
`define XPD_BIT_SMALL_RAM   2
`define XPD_BIT_LARGE_RAM   3
`define XPD_BIT_RTC         4
`define XPD_BIT_EXT_FLASH   5
`define XPD_BIT_PWM         6
`define XPD_BIT_ASYNC       7
`define XPD_BIT_SYNC        8
`define XPD_BIT_I2C         9
`define XPD_BIT_MISC        10
`define XPD_BIT_AUX_PORT    11
`define XPD_EN_RESET        12'h005
`define XPD_EN_ALL          12'hfff
`define XPD_PERIPH_MASK     12'h7d3
`define XPD_PIN_MASK        12'hfd3

// ----------------------------------------------------------------
// System configuration fields
// ----------------------------------------------------------------
`define XPD_BIT_GLOBAL      0
`define XPD_BIT_PROG_MEM    1
`define XPD_BIT_OSC_SEL     2
`define XPD_SYS_CFG_RESET   3'h0

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
`define XPD_SEG_XBUS        8'h00
`define XPD_SEG_PROG        8'h08
`define XPD_SEG_FLASH_LO    8'h09
`define XPD_SEG_FLASH_HI    8'h0e
`define XPD_SEG_LARGE_RAM   8'h0f
`define XPD_PAGE_SMALL_LO   8'he0
`define XPD_PAGE_SMALL_HI   8'he7
`define XPD_PAGE_SYNC       8'he8
`define XPD_PAGE_ASYNC      8'he9
`define XPD_PAGE_I2C        8'hea
`define XPD_PAGE_MISC_AUX   8'heb
`define XPD_PAGE_PWM        8'hec
`define XPD_PAGE_RTC        8'hed
`define XPD_PAGE_CAN_LO     8'hee
`define XPD_PAGE_CAN_HI     8'hef

`endif

/* File: xpd_pkg.sv */
// Types shared by the peripheral enable decoder and its users.
package xpd_pkg;

	// Where an access is served; one-hot.
	typedef enum logic [4:0] {
		XPD_TGT_OTHER = 5'h01,
		XPD_TGT_INT   = 5'h02,
		XPD_TGT_EXT   = 5'h04,
		XPD_TGT_RSVD  = 5'h08,
		XPD_TGT_EMU   = 5'h10
	} xpd_target_t;

	typedef enum logic [1:0] {
		XPD_OPEN   = 2'h1,
		XPD_LOCKED = 2'h2
	} xpd_lock_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} xpd_reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
	} xpd_access_t;

	typedef struct packed {
		logic        valid;
		xpd_target_t target;
	} xpd_route_t;

endpackage

/* File: xpd_enable_decode.sv */
// Peripheral enable register, write lock and on-chip/external address routing.
`timescale 1ns/1ps
`default_nettype none
`include "xpd_params.svh"

module xpd_enable_decode (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                resetn,
	// Register port
	input  wire xpd_pkg::xpd_reg_req_t reg_req,
	output var  logic [15:0]         reg_rdata,
	// Access to be routed
	input  wire xpd_pkg::xpd_access_t  access,
	output var  xpd_pkg::xpd_route_t   route,
	// Emulation strap, from a pin
	input  wire logic                emulation_mode_pin,
	// Power-down
	input  wire logic                powerdown_entry,
	output var  logic                osc_stop,
	// Pin release and effective enables
	output var  logic [11:0]         gpio_release,
	output var  logic [11:0]         periph_active
);
	import xpd_pkg::*;

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [11:0] peripheral_enable_reg;
	logic        global_periph_enable;
	logic        internal_program_mem_enable;
	logic        oscillator_stop_select;
	xpd_lock_t   lock_state;
	logic        emu_q1;
	logic        emu_q2;
	logic        emu_q3;
	logic        emu_mode;
	logic [11:0] eff_en;
	logic        wr_en_hit;
	logic        wr_cfg_hit;

	assign wr_en_hit  = reg_req.wr && (reg_req.addr == `XPD_OFS_PERIPH_EN);
	assign wr_cfg_hit = reg_req.wr && (reg_req.addr == `XPD_OFS_SYS_CFG);

	// Effective enables: emulation forces every bit on.
	assign eff_en = emu_mode ? `XPD_EN_ALL : peripheral_enable_reg;

	// ----------------------------------------------------------------
	// Emulation strap synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			emu_q1 <= 1'b0;
			emu_q2 <= 1'b0;
			emu_q3 <= 1'b0;
		end else begin
			emu_q1 <= emulation_mode_pin;
			emu_q2 <= emu_q1;
			emu_q3 <= emu_q2;
		end
	end

	// The level only counts once two stages agree, filtering a single glitch.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			emu_mode <= 1'b0;
		end else if (emu_q2 == emu_q3) begin
			emu_mode <= emu_q3;
		end
	end

	// ----------------------------------------------------------------
	// Lock state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lock_state <= XPD_OPEN;
		end else begin
			case (lock_state)
				XPD_OPEN: begin
					if (global_periph_enable) begin
						lock_state <= XPD_LOCKED;
					end
				end
				XPD_LOCKED: lock_state <= XPD_LOCKED;
				default:    lock_state <= XPD_OPEN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Peripheral enable register
	// ----------------------------------------------------------------
	// Reserved bits are not stored, so a careless write there does no harm.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			peripheral_enable_reg <= `XPD_EN_RESET;
		end else if (wr_en_hit && !global_periph_enable) begin
			peripheral_enable_reg <= reg_req.wdata[11:0];
		end
	end

	// ----------------------------------------------------------------
	// System configuration
	// ----------------------------------------------------------------
	// The global enable can only be cleared by reset, which keeps the lock stable.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			global_periph_enable        <= 1'b0;
			internal_program_mem_enable <= 1'b0;
			oscillator_stop_select      <= 1'b0;
		end else if (wr_cfg_hit) begin
			global_periph_enable        <= global_periph_enable | reg_req.wdata[`XPD_BIT_GLOBAL];
			internal_program_mem_enable <= reg_req.wdata[`XPD_BIT_PROG_MEM];
			oscillator_stop_select      <= reg_req.wdata[`XPD_BIT_OSC_SEL];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				`XPD_OFS_PERIPH_EN: reg_rdata <= {4'h0, peripheral_enable_reg};
				`XPD_OFS_SYS_CFG:   reg_rdata <= {13'h0000, oscillator_stop_select,
					internal_program_mem_enable, global_periph_enable};
				`XPD_OFS_STATUS:    reg_rdata <= {14'h0000, emu_mode,
					lock_state == XPD_LOCKED};
				`XPD_OFS_EFFECTIVE: reg_rdata <= {4'h0, eff_en};
				default:            reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Address routing
	// ----------------------------------------------------------------
	// A disabled XBus block goes external when the global enable is clear or no non-memory peripheral is on, auxiliary ports included.
	function automatic xpd_target_t xbus_pick(input logic on, input logic [11:0] en,
		input logic glob);
		if (glob && on) begin
			xbus_pick = XPD_TGT_INT;
		end else if (glob && |(en & `XPD_PIN_MASK)) begin
			xbus_pick = XPD_TGT_RSVD;
		end else begin
			xbus_pick = XPD_TGT_EXT;
		end
	endfunction

	// A disabled memory goes external unless the global enable is set and its partner memory is on.
	function automatic xpd_target_t mem_pick(input logic on, input logic partner,
		input logic glob);
		if (glob && on) begin
			mem_pick = XPD_TGT_INT;
		end else if (glob && partner) begin
			mem_pick = XPD_TGT_RSVD;
		end else begin
			mem_pick = XPD_TGT_EXT;
		end
	endfunction

	function automatic xpd_target_t route_of(input logic [23:0] a, input logic [11:0] en,
		input logic glob, input logic rom, input logic emu);
		logic [7:0] seg;
		logic [7:0] pg;
		logic       xbus_space;
		seg = a[23:16];
		pg  = a[15:8];
		xbus_space = (seg == `XPD_SEG_XBUS) && (pg >= `XPD_PAGE_SMALL_LO)
			&& (pg <= `XPD_PAGE_CAN_HI);
		route_of = XPD_TGT_OTHER;
		if (emu && (xbus_space || (seg >= `XPD_SEG_FLASH_LO && seg <= `XPD_SEG_LARGE_RAM))) begin
			route_of = XPD_TGT_EMU;
		end else if (seg == `XPD_SEG_XBUS) begin
			if (pg >= `XPD_PAGE_SMALL_LO && pg <= `XPD_PAGE_SMALL_HI) begin
				route_of = (glob && en[`XPD_BIT_SMALL_RAM]) ? XPD_TGT_INT : XPD_TGT_EXT;
			end else if (pg == `XPD_PAGE_SYNC) begin
				route_of = xbus_pick(en[`XPD_BIT_SYNC], en, glob);
			end else if (pg == `XPD_PAGE_ASYNC) begin
				route_of = xbus_pick(en[`XPD_BIT_ASYNC], en, glob);
			end else if (pg == `XPD_PAGE_I2C) begin
				route_of = xbus_pick(en[`XPD_BIT_I2C], en, glob);
			end else if (pg == `XPD_PAGE_MISC_AUX && !a[7]) begin
				route_of = xbus_pick(en[`XPD_BIT_MISC], en, glob);
			end else if (pg == `XPD_PAGE_MISC_AUX) begin
				route_of = xbus_pick(en[`XPD_BIT_AUX_PORT], en, glob);
			end else if (pg == `XPD_PAGE_PWM) begin
				route_of = xbus_pick(en[`XPD_BIT_PWM], en, glob);
			end else if (pg == `XPD_PAGE_RTC) begin
				route_of = xbus_pick(en[`XPD_BIT_RTC], en, glob);
			end else if (pg >= `XPD_PAGE_CAN_LO && pg <= `XPD_PAGE_CAN_HI) begin
				route_of = xbus_pick(en[`XPD_BIT_FIRST_CAN] | en[`XPD_BIT_SECOND_CAN],
					en, glob);
			end
		end else if (seg == `XPD_SEG_PROG) begin
			if (rom) begin
				route_of = XPD_TGT_INT;
			end else if (!glob) begin
				route_of = XPD_TGT_EXT;
			end else if (en[`XPD_BIT_LARGE_RAM] || en[`XPD_BIT_EXT_FLASH]) begin
				route_of = XPD_TGT_RSVD;
			end else begin
				route_of = XPD_TGT_EXT;
			end
		end else if (seg >= `XPD_SEG_FLASH_LO && seg <= `XPD_SEG_FLASH_HI) begin
			route_of = mem_pick(en[`XPD_BIT_EXT_FLASH], en[`XPD_BIT_LARGE_RAM], glob);
		end else if (seg == `XPD_SEG_LARGE_RAM) begin
			route_of = mem_pick(en[`XPD_BIT_LARGE_RAM], en[`XPD_BIT_EXT_FLASH], glob);
		end
	endfunction

	// The routing answer stands one cycle after the access is presented.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			route <= '{valid: 1'b0, target: XPD_TGT_OTHER};
		end else begin
			route.valid  <= access.valid;
			route.target <= access.valid ? route_of(access.addr, eff_en, global_periph_enable,
				internal_program_mem_enable, emu_mode) : XPD_TGT_OTHER;
		end
	end

	// ----------------------------------------------------------------
	// Pins and oscillator
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gpio_release  <= ~`XPD_EN_RESET & `XPD_PIN_MASK;
			periph_active <= `XPD_EN_RESET;
		end else begin
			gpio_release  <= ~eff_en & `XPD_PIN_MASK;
			periph_active <= eff_en;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			osc_stop <= 1'b0;
		end else begin
			osc_stop <= powerdown_entry && (!eff_en[`XPD_BIT_RTC] || oscillator_stop_select);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_locked_write;
		global_periph_enable && wr_en_hit;
	endsequence

	sequence s_open_write;
		!global_periph_enable && wr_en_hit;
	endsequence

	a_lock_holds_value: assert property (s_locked_write |=> $stable(peripheral_enable_reg))
		else $error("enable register changed while locked");
	a_open_write_stores: assert property (s_open_write |=>
		peripheral_enable_reg == $past(reg_req.wdata[11:0]))
		else $error("open write not stored");
	a_lock_sticks: assert property (lock_state == XPD_LOCKED |=> global_periph_enable
		&& lock_state == XPD_LOCKED)
		else $error("lock released without reset");
	a_emu_forces_all: assert property (emu_mode |=> periph_active == `XPD_EN_ALL)
		else $error("emulation did not force enables");
	a_pins_follow_en: assert property (##1 gpio_release == (~$past(eff_en) & `XPD_PIN_MASK))
		else $error("pin release does not follow enables");
	a_osc_rtc_off: assert property (powerdown_entry && !eff_en[`XPD_BIT_RTC] |=> osc_stop)
		else $error("oscillator not stopped with clock block off");
	a_route_one_cycle: assert property (access.valid |=> route.valid ##1 !route.valid
		|| $past(access.valid))
		else $error("route answer not one cycle after access");
	a_small_ram_ext: assert property (access.valid && !eff_en[`XPD_BIT_SMALL_RAM] && !emu_mode
		&& access.addr[23:11] == 13'h001c |=> route.target == XPD_TGT_EXT)
		else $error("small RAM range not external when disabled");
	a_seg8_rom: assert property (access.valid && internal_program_mem_enable
		&& access.addr[23:16] == `XPD_SEG_PROG |=> route.target == XPD_TGT_INT)
		else $error("segment 8 not internal with program memory on");
	a_idle_xbus_ext: assert property (access.valid && !emu_mode && !global_periph_enable
		&& access.addr[23:11] == 13'h001d |=> route.target == XPD_TGT_EXT)
		else $error("XBus range not external with peripherals off");

	a_lock_follows: assert property (global_periph_enable |=> lock_state == XPD_LOCKED)
		else $error("lock state does not follow the global enable");
	a_emu_filter: assert property (emu_q2 == emu_q3 |=> emu_mode == $past(emu_q3))
		else $error("emulation level not taken once stages agree");
	a_emu_routes: assert property (access.valid && emu_mode
		&& access.addr[23:16] == `XPD_SEG_LARGE_RAM |=> route.target == XPD_TGT_EMU)
		else $error("emulation range not handed to the emulation chip");
	a_route_idle: assert property (!access.valid |=> !route.valid
		&& route.target == XPD_TGT_OTHER)
		else $error("route answer without an access");
	a_osc_idle: assert property (!powerdown_entry |=> !osc_stop)
		else $error("oscillator stopped outside power-down");
	a_osc_select: assert property (powerdown_entry && eff_en[`XPD_BIT_RTC]
		|=> osc_stop == $past(oscillator_stop_select))
		else $error("oscillator stop ignores the select bit");

	// ----------------------------------------------------------------
	// On-chip service of enabled blocks
	// ----------------------------------------------------------------
	// An enabled block is only served on-chip once the global enable is set.
	sequence s_served_page(logic [7:0] page, logic bit_on);
		access.valid && !emu_mode && global_periph_enable && bit_on
			&& access.addr[23:8] == {8'h00, page};
	endsequence

	sequence s_internal_answer;
		route.valid && route.target == XPD_TGT_INT;
	endsequence

	a_sync_served: assert property (s_served_page(`XPD_PAGE_SYNC, eff_en[`XPD_BIT_SYNC])
		|=> s_internal_answer)
		else $error("sync serial range not served on-chip");
	a_async_served: assert property (s_served_page(`XPD_PAGE_ASYNC, eff_en[`XPD_BIT_ASYNC])
		|=> s_internal_answer)
		else $error("async serial range not served on-chip");
	a_i2c_served: assert property (s_served_page(`XPD_PAGE_I2C, eff_en[`XPD_BIT_I2C])
		|=> s_internal_answer)
		else $error("I2C range not served on-chip");
	a_pwm_served: assert property (s_served_page(`XPD_PAGE_PWM, eff_en[`XPD_BIT_PWM])
		|=> s_internal_answer)
		else $error("PWM range not served on-chip");
	a_rtc_served: assert property (s_served_page(`XPD_PAGE_RTC, eff_en[`XPD_BIT_RTC])
		|=> s_internal_answer)
		else $error("clock block range not served on-chip");
	a_misc_served: assert property (s_served_page(`XPD_PAGE_MISC_AUX, eff_en[`XPD_BIT_MISC])
		##0 !access.addr[7] |=> s_internal_answer)
		else $error("misc feature range not served on-chip");
	a_aux_served: assert property (s_served_page(`XPD_PAGE_MISC_AUX, eff_en[`XPD_BIT_AUX_PORT])
		##0 access.addr[7] |=> s_internal_answer)
		else $error("aux port range not served on-chip");
	a_can_served: assert property (s_served_page(`XPD_PAGE_CAN_HI,
		eff_en[`XPD_BIT_FIRST_CAN] | eff_en[`XPD_BIT_SECOND_CAN]) |=> s_internal_answer)
		else $error("CAN range not served on-chip");

	// Memories answer on-chip when enabled, segment 8 turns reserved beside them.
	a_flash_served: assert property (access.valid && !emu_mode && global_periph_enable
		&& eff_en[`XPD_BIT_EXT_FLASH] && access.addr[23:16] >= `XPD_SEG_FLASH_LO
		&& access.addr[23:16] <= `XPD_SEG_FLASH_HI |=> s_internal_answer)
		else $error("extension flash not served on-chip");
	a_large_ram_served: assert property (access.valid && !emu_mode && global_periph_enable
		&& eff_en[`XPD_BIT_LARGE_RAM] && access.addr[23:16] == `XPD_SEG_LARGE_RAM |=> s_internal_answer)
		else $error("large extension RAM not served on-chip");
	a_seg8_reserved: assert property (access.valid && !internal_program_mem_enable
		&& global_periph_enable && (eff_en[`XPD_BIT_LARGE_RAM] || eff_en[`XPD_BIT_EXT_FLASH])
		&& access.addr[23:16] == `XPD_SEG_PROG |=> route.target == XPD_TGT_RSVD)
		else $error("segment 8 not reserved with extension memory on");

endmodule
`default_nettype wire

/* File: xpd_cpu_model.sv */
// CPU-side model that places bench requests on the register port and the routing port.
`timescale 1ns/1ps
`default_nettype none
module xpd_cpu_model (
	// Requests from the bench
	input  wire logic                  cmd_wr,
	input  wire logic                  cmd_rd,
	input  wire logic [7:0]            cmd_addr,
	input  wire logic [15:0]           cmd_wdata,
	input  wire logic                  cmd_acc,
	input  wire logic [23:0]           cmd_acc_addr,
	// Bus side
	output var  xpd_pkg::xpd_reg_req_t reg_req,
	output var  xpd_pkg::xpd_access_t  access
);
	import xpd_pkg::*;
	logic [15:0] wmask;
	// Software keeps reserved bits at zero, so the bench cannot hand the design an illegal value by accident.
	assign wmask = (cmd_addr == 8'h00) ? 16'h0fff : ((cmd_addr == 8'h04) ? 16'h0007 : 16'hffff);
	assign reg_req = '{wr: cmd_wr, rd: cmd_rd, addr: cmd_addr, wdata: cmd_wdata & wmask};
	assign access = '{valid: cmd_acc, addr: cmd_acc_addr};
endmodule
`default_nettype wire

/* File: xpd_enable_decode_tb.sv */
// Self-checking testbench of the peripheral enable decoder.
`timescale 1ns/1ps
`default_nettype none
module xpd_enable_decode_tb;
	import xpd_pkg::*;
	logic                  core_clk = 1'b0;
	logic                  resetn = 1'b0;
	logic                  cmd_wr = 1'b0;
	logic                  cmd_rd = 1'b0;
	logic [7:0]            cmd_addr = 8'h00;
	logic [15:0]           cmd_wdata = 16'h0000;
	logic                  cmd_acc = 1'b0;
	logic [23:0]           cmd_acc_addr = 24'h000000;
	logic                  emu_pin = 1'b0;
	logic                  pd = 1'b0;
	xpd_reg_req_t          reg_req;
	xpd_access_t           access;
	logic [15:0]           reg_rdata;
	xpd_route_t            route;
	logic                  osc_stop;
	logic [11:0]           gpio_release;
	logic [11:0]           periph_active;
	int                    err_count = 0;
	int                    num_checks = 0;
	int                    seed = 32'hfa17;
	int                    m_en, m_glob, m_rom, m_osc, m_emu;
	logic [23:0]           addrs [21] = '{24'h00e000, 24'h00e7ff, 24'h00e800, 24'h00e8ff, 24'h00e900, 24'h00ea10,
		24'h00eb00, 24'h00eb7f, 24'h00eb80, 24'h00ebff, 24'h00ec00, 24'h00ed00, 24'h00ee00, 24'h00efff,
		24'h080000, 24'h090000, 24'h0effff, 24'h0f0000, 24'h0fffff, 24'h00d000, 24'h00ecff};

	always #2.5 core_clk = ~core_clk;

	xpd_cpu_model cpu (.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_acc(cmd_acc), .cmd_acc_addr(cmd_acc_addr), .reg_req(reg_req), .access(access));
	xpd_enable_decode uut (.core_clk(core_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.access(access), .route(route), .emulation_mode_pin(emu_pin), .powerdown_entry(pd),
		.osc_stop(osc_stop), .gpio_release(gpio_release), .periph_active(periph_active));

	// ----------------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------------
	function automatic xpd_target_t exp_tgt(input logic [23:0] a);
		logic [7:0]  sg;
		logic [7:0]  pg;
		logic [11:0] en;
		logic        on;
		logic        mate;
		sg = a[23:16];
		pg = a[15:8];
		en = (m_emu != 0) ? 12'hfff : m_en[11:0];
		if (sg == 8'h08) begin
			if (m_rom != 0) return XPD_TGT_INT;
			return (m_glob == 0 || (en[3] == 1'b0 && en[5] == 1'b0)) ? XPD_TGT_EXT : XPD_TGT_RSVD;
		end
		if (m_emu != 0 && ((sg == 8'h00 && pg >= 8'he0 && pg <= 8'hef) || (sg >= 8'h09 && sg <= 8'h0f)))
			return XPD_TGT_EMU;
		if (sg >= 8'h09 && sg <= 8'h0f) begin
			on = (sg == 8'h0f) ? en[3] : en[5];
			mate = (sg == 8'h0f) ? en[5] : en[3];
			if (m_glob != 0 && on) return XPD_TGT_INT;
			return (m_glob == 0 || !mate) ? XPD_TGT_EXT : XPD_TGT_RSVD;
		end
		if (sg != 8'h00 || pg < 8'he0 || pg > 8'hef) return XPD_TGT_OTHER;
		if (pg <= 8'he7) return (m_glob != 0 && en[2]) ? XPD_TGT_INT : XPD_TGT_EXT;
		case (pg)
			8'he8: on = en[8];
			8'he9: on = en[7];
			8'hea: on = en[9];
			8'heb: on = a[7] ? en[11] : en[10];
			8'hec: on = en[6];
			8'hed: on = en[4];
			default: on = en[0] | en[1];
		endcase
		if (m_glob != 0 && on) return XPD_TGT_INT;
		return (m_glob == 0 || (en & 12'hfd3) == 12'h000) ? XPD_TGT_EXT : XPD_TGT_RSVD;
	endfunction

	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		cmd_wr <= 1'b1;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		if (a == 8'h00 && m_glob == 0) m_en = d & 16'h0fff;
		if (a == 8'h04) begin
			m_glob = m_glob | d[0];
			m_rom = d[1];
			m_osc = d[2];
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		cmd_rd <= 1'b1;
		cmd_addr <= a;
		@(posedge core_clk);
		cmd_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask

	task automatic route_chk(input logic [23:0] a);
		@(posedge core_clk);
		cmd_acc <= 1'b1;
		cmd_acc_addr <= a;
		@(posedge core_clk);
		cmd_acc <= 1'b0;
		#1;
		chk(route.valid, 1'b1);
		chk(route.target, exp_tgt(a));
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		{m_en, m_glob, m_rom, m_osc, m_emu} = {32'h005, 32'h0, 32'h0, 32'h0, 32'h0};
	endtask

	task automatic check_all();
		logic [11:0] eff;
		int          i;
		eff = (m_emu != 0) ? 12'hfff : m_en[11:0];
		@(posedge core_clk);
		#1;
		chk(periph_active, eff);
		chk(gpio_release, ~eff & 12'hfd3);
		for (i = 0; i < 21; i++) route_chk(addrs[i]);
		rd_chk(8'h08, {14'h0, m_emu[0], m_glob[0]});
		rd_chk(8'h0c, {4'h0, eff});
		if (m_emu == 0) rd_chk(8'h00, m_en[15:0]);
		@(posedge core_clk);
		pd <= 1'b1;
		@(posedge core_clk);
		pd <= 1'b0;
		#1;
		chk(osc_stop, !eff[4] || m_osc != 0);
		@(posedge core_clk);
		#1;
		chk(osc_stop, 1'b0);
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Each configuration starts from reset because the global enable can only be cleared by reset.
	initial begin
		logic [15:0] en;
		logic [15:0] sys;
		logic [15:0] cfg_en [4] = '{16'h0000, 16'h0fff, 16'h0028, 16'h07d3};
		logic [15:0] cfg_sys [4] = '{16'h0001, 16'h0005, 16'h0003, 16'h0001};
		int          n;
		do_reset();
		check_all();
		rd_chk(8'h44, 16'h0000);
		rd_chk(8'h00, 16'h0005);
		@(posedge core_clk);
		#1;
		chk(reg_rdata, 16'h0000);
		for (n = 0; n < 10; n++) begin
			do_reset();
			en = (n < 4) ? cfg_en[n] : 16'($random(seed));
			sys = (n < 4) ? cfg_sys[n] : 16'($random(seed));
			wr(8'h00, en);
			check_all();
			wr(8'h04, sys);
			// Once the global enable is set and a block under mask 07d3 is on, check the route of an address in the misc page.
			if (sys[0] && (en & 16'h07d3) != 16'h0000) route_chk(24'h00eb7e);
			check_all();
			wr(8'h00, ~en);
			wr(8'h44, 16'hffff);
			check_all();
		end
		do_reset();
		wr(8'h00, 16'h0000);
		emu_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		m_emu = 1;
		check_all();
		wrap_up();
	end

	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
